//--- iobd_cpu_model.sv
`timescale 1ns/10ps
// Processor side: one strobe cycle per go, then a channel ack if a request came back
module iobd_cpu_model
  import iobd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic channelRequestLine,
  output logic      requestEnableStrobe,
  output logic      channelAddressAck,
  output logic      idle
);
  logic [2:0] step_q;

  // Step counter; a go while running is ignored so a cycle is never cut short
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      step_q <= 3'h0;
    else if (step_q != 3'h0 || go)
      step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
  end

  // Strobe stays high two cycles, as in every processor cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      requestEnableStrobe <= 1'b0;
    else
      requestEnableStrobe <= (step_q == 3'h0 && go) || step_q == 3'h1;
  end

  // Ack only once the strobe has ended, and only for a returned request
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      channelAddressAck <= 1'b0;
    else if (step_q == 3'h2)
      channelAddressAck <= channelRequestLine;
    else if (step_q == 3'h4)
      channelAddressAck <= 1'b0;
  end

  assign idle = step_q == 3'h0;
endmodule

//--- iobd_device.sv
// Notes on behaviour
// RQ1 - Processor runs consecutive channel cycles when requests keep arriving.
// RQ2 - Serviced device drops channel request on strobe unless sync set again.
// RQ3 - Same strobe edge still sets requests in other needing devices.
// RQ4 - Processor issues further channel acks after each access when requests remain.
// RQ5 - Each channel ack selects the priority holder and deselects all others.
// RQ6 - Channel request line answers strobe within 75 ns.
// RQ7 - High-speed devices sit nearest processor; last one feeds speed return point.
// RQ8 - Burst mode: assert request and pull wait low; release wait to transfer.
// RQ9 - Control flipflops capture on clock edge; resets override.
// RQ10 - Device select compares selection lines against own code.
// RQ11 - IO reset clears busy, done, mask and interrupt request.
// RQ12 - Mask flag changes only from its mask bit on mask-out pulse.
// RQ13 - Control pulses act only while device is selected. Code gates start and clear only; mask out acts unselected.
// RQ14 - Clear resets busy, done, int request; start clears done, request, sets busy.
// RQ15 - Selected device shows busy and done on sense lines.
// RQ16 - Completion clears busy and sets done.
// RQ17 - Done taken from busy stays clear if software cleared busy first.
// RQ18 - Strobe edge sets int request when done and unmasked; drives request line.
// RQ19 - Mask set or done clear drops int request at next strobe edge.
// RQ20 - Priority passed onward only while own int request clear.
// RQ21 - Acknowledged requesting priority holder drives its code on lines 10-15.
// RQ22 - Data lines driven only for one bits.
// RQ23 - Channel priority passed onward only while channel request clear.
// RQ24 - Channel ack edge selects requesting holder and clears its sync flag.
// RQ25 - Selected device drives transfer mode lines for its transfer type.
// RQ26 - Clearing busy also clears channel sync.
// RQ27 - IO reset also clears sync, channel request and channel select.
`timescale 1ns/10ps
module iobd_device
  import iobd_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [5:0]        devSelect,
  input  wire logic              ioReset,
  input  wire logic              startPulse,
  input  wire logic              clearPulse,
  input  wire logic              maskOutPulse,
  input  wire logic [DATA_W-1:0] dataLinesIn,
  input  wire logic              requestEnableStrobe,
  input  wire logic              channelAddressAck,
  input  wire logic              interruptAckStrobe,
  input  wire logic              interruptPriorityChainInN,
  input  wire logic              channelPriorityChainInN,
  output logic [DATA_W-1:0]      dataLinesOeN,
  output logic                   busySenseLine,
  output logic                   doneSenseLine,
  output logic                   interruptRequestLine,
  output logic                   interruptPriorityChainOutN,
  output logic                   channelRequestLine,
  output logic                   channelPriorityChainOutN,
  output logic [1:0]             transferModeLines,
  output logic                   waitLineOeN
);

  // Elaboration checks
  if (DATA_W < 16)
    $error("iobd_device: DATA_W must be at least 16");
  if (CHAN_REQ_LATENCY > CHAN_REQ_MAX_CYC)
    $error("iobd_device: channel request response too slow for clock rate");

  iobd_cfg_t cfg_q;
  logic      busy_q;
  logic      done_q;
  logic      intMask_q;
  logic      intReq_q;
  logic      chanSync_q;
  logic      chanReq_q;
  logic      chanSel_q;
  logic      waitLow_q;
  logic      selected;
  logic      rqRise;
  logic      ackRise;
  logic      busWrite;
  logic      complete;
  logic      syncSet;
  logic      burstGo;
  logic      ctrlStart;
  logic      ctrlClear;
  logic      intPrioIn;
  logic      chanPrioIn;
  logic      chanWin;
  logic      busyClearing;
  iobd_status_t status;

  // Leading edges of the processor's strobes
  iobd_edge_detect u_rq_edge
  (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (requestEnableStrobe),
    .rise     (rqRise)
  );

  iobd_edge_detect u_ack_edge
  (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (channelAddressAck),
    .rise     (ackRise)
  );

  // Device select decode against own code
  assign selected = (devSelect == cfg_q.devCode); // RQ10

  // Control pulses gated by select
  assign ctrlStart = startPulse & selected; // RQ13
  assign ctrlClear = clearPulse & selected; // RQ13

  // Active-low chains turned into true levels
  assign intPrioIn  = ~interruptPriorityChainInN;
  assign chanPrioIn = ~channelPriorityChainInN;
  assign chanWin    = chanPrioIn & chanReq_q;

  // Register-side pulses, taken on the completing bus edge
  assign busWrite = avs_write & ~avs_waitrequest;
  assign complete = busWrite & (avs_address == REG_CTRL_OFS) & avs_writedata[CTRL_COMPLETE_BIT];
  assign syncSet  = busWrite & (avs_address == REG_CTRL_OFS) & avs_writedata[CTRL_SYNC_SET_BIT];
  assign burstGo  = busWrite & (avs_address == REG_CTRL_OFS) & avs_writedata[CTRL_BURST_GO_BIT];

  // Busy falls on clear or on completion, unless start arrives too
  assign busyClearing = busy_q & ~ctrlStart & (ctrlClear | complete);

  // Bus slave handshake: one wait cycle, then the access completes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if ((avs_read | avs_write) & avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Read data, registered as the wait drops; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & avs_waitrequest)
    begin
      case (avs_address)
        REG_CTRL_OFS:
          avs_readdata <= {25'h000_0000, 1'b0, cfg_q.burstEnable, cfg_q.doneFromBusy, cfg_q.mode, 2'h0};
        REG_CONFIG_OFS:
          avs_readdata <= {20'h0_0000, cfg_q.maskBit, 2'h0, cfg_q.devCode};
        REG_STATUS_OFS:
          avs_readdata <= {24'h00_0000, status};
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign status = '{waitLow: waitLow_q, chanSel: chanSel_q, chanReq: chanReq_q,
                    chanSync: chanSync_q, intReq: intReq_q, intMask: intMask_q,
                    done: done_q, busy: busy_q};

  // Software configuration; writes elsewhere are ignored
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cfg_q <= '{mode: IOBD_XFER_DATA_OUT, doneFromBusy: 1'b0, burstEnable: 1'b0,
                 maskBit: MASK_BIT_RST, devCode: DEV_CODE_RST};
    else if (busWrite & (avs_address == REG_CTRL_OFS))
    begin
      cfg_q.mode         <= iobd_xfer_t'(avs_writedata[CTRL_MODE_LSB +: 2]);
      cfg_q.doneFromBusy <= avs_writedata[CTRL_DONE_DEP_BIT];
      cfg_q.burstEnable  <= avs_writedata[CTRL_BURST_EN_BIT];
    end
    else if (busWrite & (avs_address == REG_CONFIG_OFS))
    begin
      cfg_q.devCode <= avs_writedata[CFG_CODE_LSB +: 6];
      cfg_q.maskBit <= avs_writedata[CFG_MASK_LSB +: 4];
    end
  end

  // Busy: IO reset first, start beats clear and completion
  always_ff @(posedge core_clk or posedge rst) // RQ9
  begin
    if (rst)
      busy_q <= 1'b0;
    else if (ioReset)
      busy_q <= 1'b0; // RQ11
    else if (ctrlStart)
      busy_q <= 1'b1; // RQ14
    else if (ctrlClear | complete)
      busy_q <= 1'b0; // RQ16
  end

  // Done: completion sets it, optionally only if still busy
  always_ff @(posedge core_clk or posedge rst) // RQ9
  begin
    if (rst)
      done_q <= 1'b0;
    else if (ioReset)
      done_q <= 1'b0; // RQ11
    else if (ctrlStart | ctrlClear)
      done_q <= 1'b0; // RQ14
    else if (complete)
      done_q <= cfg_q.doneFromBusy ? busy_q : 1'b1; // RQ16 RQ17
  end

  // Interrupt mask: only the mask word's chosen bit steers it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      intMask_q <= 1'b0;
    else if (ioReset)
      intMask_q <= 1'b0; // RQ11
    else if (maskOutPulse)
      intMask_q <= dataLinesIn[DATA_W - 1 - int'(cfg_q.maskBit)]; // RQ12
  end

  // Interrupt request follows done and mask only at strobe edges,
  // so the serial priority chain has settled before acknowledge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      intReq_q <= 1'b0;
    else if (ioReset)
      intReq_q <= 1'b0; // RQ11
    else if (ctrlStart | ctrlClear)
      intReq_q <= 1'b0; // RQ14
    else if (rqRise)
      intReq_q <= done_q & ~intMask_q; // RQ18 RQ19
  end

  // Channel sync: set by the device side, cleared by ack, busy drop or reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chanSync_q <= 1'b0;
    else if (ioReset)
      chanSync_q <= 1'b0; // RQ27
    else if (syncSet & busy_q & ~busyClearing)
      chanSync_q <= 1'b1; // New request wins over the ack clear
    else if (busyClearing)
      chanSync_q <= 1'b0; // RQ26
    else if (ackRise & chanWin)
      chanSync_q <= 1'b0; // RQ24
  end

  // Channel request: sampled from sync at every strobe edge, forced high there in burst mode while busy. A serviced
  // device whose sync was re-armed keeps requesting at full rate.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chanReq_q <= 1'b0;
    else if (ioReset)
      chanReq_q <= 1'b0; // RQ27
    else if (rqRise & cfg_q.burstEnable & busy_q)
      chanReq_q <= 1'b1; // RQ8
    else if (rqRise)
      chanReq_q <= chanSync_q; // RQ2 RQ3 RQ6
  end

  // Channel select: every ack edge re-decides, deselecting losers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chanSel_q <= 1'b0;
    else if (ioReset)
      chanSel_q <= 1'b0; // RQ27
    else if (ackRise)
      chanSel_q <= chanWin; // RQ5 RQ24
  end

  // Burst wait: pulled low with each request, released by software go
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      waitLow_q <= 1'b0;
    else if (ioReset | ~cfg_q.burstEnable)
      waitLow_q <= 1'b0;
    else if (rqRise & busy_q)
      waitLow_q <= 1'b1; // RQ8
    else if (burstGo)
      waitLow_q <= 1'b0; // RQ8
  end

  // Sense lines show state only while addressed
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      busySenseLine <= 1'b0;
      doneSenseLine <= 1'b0;
    end
    else
    begin
      busySenseLine <= selected & busy_q; // RQ15
      doneSenseLine <= selected & done_q; // RQ15
    end
  end

  // Request lines are copies of the flags, never of done
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      interruptRequestLine <= 1'b0;
      channelRequestLine   <= 1'b0;
    end
    else
    begin
      interruptRequestLine <= ioReset ? 1'b0 : ((ctrlStart | ctrlClear) ? 1'b0 :
                              (rqRise ? (done_q & ~intMask_q) : intReq_q)); // RQ18
      channelRequestLine   <= ioReset ? 1'b0 : (rqRise ? (chanSync_q | (cfg_q.burstEnable & busy_q))
                              : chanReq_q); // RQ6
    end
  end

  // Priority chains, active low; registered, so each stage adds a cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      interruptPriorityChainOutN <= 1'b1;
      channelPriorityChainOutN   <= 1'b1;
    end
    else
    begin
      interruptPriorityChainOutN <= ~(intPrioIn & ~intReq_q); // RQ20
      channelPriorityChainOutN   <= ~(chanPrioIn & ~chanReq_q); // RQ23 RQ7
    end
  end

  // Mode lines driven only while selected for the channel
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      transferModeLines <= 2'h0;
    else
      transferModeLines <= chanSel_q ? cfg_q.mode : 2'h0; // RQ25
  end

  // Device code on lines 10-15 during acknowledge; ones only are driven
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dataLinesOeN <= '1;
    else
    begin
      dataLinesOeN <= '1;
      if (interruptAckStrobe & intReq_q & intPrioIn) // RQ21
        dataLinesOeN[5:0] <= ~cfg_q.devCode; // RQ22
    end
  end

  // Wait pin is open drain: enable low means pulling the line low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      waitLineOeN <= 1'b1;
    else
      waitLineOeN <= ~waitLow_q; // RQ8
  end

endmodule

//--- iobd_device_checker.sv
`timescale 1ns/10ps
// Port-level watch on the bus device; it sees only the top ports
module iobd_device_checker
  import iobd_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [3:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [5:0]        devSelect,
  input wire logic              ioReset,
  input wire logic              startPulse,
  input wire logic              clearPulse,
  input wire logic              maskOutPulse,
  input wire logic [DATA_W-1:0] dataLinesIn,
  input wire logic              requestEnableStrobe,
  input wire logic              channelAddressAck,
  input wire logic              interruptAckStrobe,
  input wire logic              interruptPriorityChainInN,
  input wire logic              channelPriorityChainInN,
  input wire logic [DATA_W-1:0] dataLinesOeN,
  input wire logic              busySenseLine,
  input wire logic              doneSenseLine,
  input wire logic              interruptRequestLine,
  input wire logic              interruptPriorityChainOutN,
  input wire logic              channelRequestLine,
  input wire logic              channelPriorityChainOutN,
  input wire logic [1:0]        transferModeLines,
  input wire logic              waitLineOeN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Strobe leading edge as seen one sample back; request lines rise only then
  sequence s_edge;
    $past(requestEnableStrobe) && !$past(requestEnableStrobe, 2);
  endsequence
  sequence s_iorst;
    $past(ioReset);
  endsequence

  // Register bus: exactly one wait cycle per access
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low");
  a_request_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  a_int_on_edge: assert property ($rose(interruptRequestLine) |-> s_edge)
    else $error("interrupt request rose off the strobe edge");
  a_int_chain_pass: assert property (1 |=> interruptPriorityChainOutN == $past(interruptRequestLine || interruptPriorityChainInN))
    else $error("interrupt priority out wrong");
  a_chan_on_edge: assert property ($changed(channelRequestLine) |-> s_edge or s_iorst)
    else $error("channel request moved off the strobe edge");
  a_chan_chain_pass: assert property (1 |=> channelPriorityChainOutN == $past(channelRequestLine || channelPriorityChainInN))
    else $error("channel priority out wrong");
  a_code_only_ack: assert property (!(interruptAckStrobe && interruptRequestLine && !interruptPriorityChainInN) |=> &dataLinesOeN)
    else $error("data lines driven without acknowledge");
  a_mode_after_ack: assert property ($rose(|transferModeLines) |-> $past(channelAddressAck, 2))
    else $error("mode lines rose without channel ack");
  a_wait_with_req: assert property ($fell(waitLineOeN) |-> channelRequestLine)
    else $error("wait pulled low without channel request");
  a_io_reset_clears: assert property (ioReset |=> !interruptRequestLine && !channelRequestLine ##1 waitLineOeN && !busySenseLine && !doneSenseLine && transferModeLines == 2'h0)
    else $error("io reset left state behind");
endmodule

bind iobd_device iobd_device_checker #(.DATA_W(DATA_W)) i_iobd_device_checker
(
  .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .devSelect, .ioReset, .startPulse, .clearPulse, .maskOutPulse, .dataLinesIn, .requestEnableStrobe,
  .channelAddressAck, .interruptAckStrobe, .interruptPriorityChainInN, .channelPriorityChainInN,
  .dataLinesOeN, .busySenseLine, .doneSenseLine, .interruptRequestLine, .interruptPriorityChainOutN,
  .channelRequestLine, .channelPriorityChainOutN, .transferModeLines, .waitLineOeN
);

//--- iobd_device_tb.sv
`timescale 1ns/10ps
// Bench: register accesses, processor cycles and control pulses with expected status
module iobd_device_tb
  import iobd_pkg::*;
;
  logic        core_clk, rst, avs_read, avs_write, ioReset, startPulse, clearPulse, maskOutPulse;
  logic        interruptAckStrobe, go, idle, requestEnableStrobe, channelAddressAck, waitLineOeN;
  logic        interruptPriorityChainInN, channelPriorityChainInN, avs_waitrequest, busySenseLine;
  logic        doneSenseLine, interruptRequestLine, interruptPriorityChainOutN, channelRequestLine;
  logic        channelPriorityChainOutN;
  logic [1:0]  transferModeLines;
  logic [3:0]  avs_address;
  logic [5:0]  devSelect;
  logic [15:0] dataLinesIn, dataLinesOeN;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  int          errors = 0;
  int          comparisons = 0;

  iobd_device i_iobd_device
  (
    .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .devSelect, .ioReset, .startPulse, .clearPulse, .maskOutPulse, .dataLinesIn, .requestEnableStrobe,
    .channelAddressAck, .interruptAckStrobe, .interruptPriorityChainInN, .channelPriorityChainInN,
    .dataLinesOeN, .busySenseLine, .doneSenseLine, .interruptRequestLine, .interruptPriorityChainOutN,
    .channelRequestLine, .channelPriorityChainOutN, .transferModeLines, .waitLineOeN
  );

  iobd_cpu_model i_iobd_cpu_model
  (
    .core_clk, .rst, .go, .channelRequestLine, .requestEnableStrobe, .channelAddressAck, .idle
  );

  // 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One access; held until waitrequest is sampled low, whatever the latency
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic st(input logic [31:0] exp);
    bus(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rdata, exp);
  endtask

  // One-cycle control pulses: bit0 start, bit1 clear, bit2 mask out
  task automatic pulse(input logic [2:0] p);
    @(posedge core_clk);
    {maskOutPulse, clearPulse, startPulse} <= p;
    @(posedge core_clk);
    {maskOutPulse, clearPulse, startPulse} <= 3'h0;
  endtask

  // Lets the processor model run one full cycle; two more edges for lagging outputs
  task automatic cyc;
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    do
      @(posedge core_clk);
    while (idle !== 1'b1);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial
  begin
    {rst, avs_read, avs_write, ioReset, startPulse, clearPulse, maskOutPulse, interruptAckStrobe, go} = 9'h100;
    {avs_address, avs_writedata, devSelect, dataLinesIn} = '0;
    {interruptPriorityChainInN, channelPriorityChainInN} = 2'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    st(32'h0);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b1, REG_STATUS_OFS, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rdata, 32'h0);
    bus(1'b1, REG_CONFIG_OFS, 32'h32a);
    devSelect <= 6'h15;
    pulse(3'h1);
    st(32'h0);
    devSelect <= 6'h2a;
    pulse(3'h1);
    st(32'h1);
    chk(32'(busySenseLine), 32'h1);
    bus(1'b1, REG_CTRL_OFS, 32'ha);
    st(32'h11);
    cyc();
    st(32'h61);
    chk(32'(channelRequestLine), 32'h1);
    chk(32'(transferModeLines), 32'h2);
    chk(32'(channelPriorityChainOutN), 32'h1);
    bus(1'b1, REG_CTRL_OFS, 32'ha);
    cyc();
    st(32'h61);
    cyc();
    st(32'h41);
    chk(32'(channelRequestLine), 32'h0);
    chk(32'(channelPriorityChainOutN), 32'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h9);
    st(32'h42);
    chk(32'(doneSenseLine), 32'h1);
    cyc();
    st(32'h4a);
    chk(32'(interruptRequestLine), 32'h1);
    chk(32'(interruptPriorityChainOutN), 32'h1);
    // Without incoming priority the acknowledge must leave the data lines alone
    interruptPriorityChainInN <= 1'b1;
    interruptAckStrobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(dataLinesOeN), 32'hffff);
    interruptPriorityChainInN <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(dataLinesOeN), 32'hffd5);
    interruptAckStrobe <= 1'b0;
    dataLinesIn <= 16'h1000;
    pulse(3'h4);
    st(32'h4e);
    cyc();
    st(32'h46);
    chk(32'(interruptPriorityChainOutN), 32'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h18);
    pulse(3'h1);
    st(32'h45);
    pulse(3'h2);
    st(32'h44);
    bus(1'b1, REG_CTRL_OFS, 32'h19);
    st(32'h44);
    pulse(3'h1);
    bus(1'b1, REG_CTRL_OFS, 32'h1a);
    pulse(3'h2);
    st(32'h44);
    pulse(3'h1);
    bus(1'b1, REG_CTRL_OFS, 32'h28);
    cyc();
    st(32'he5);
    chk(32'(waitLineOeN), 32'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h68);
    st(32'h65);
    chk(32'(waitLineOeN), 32'h1);
    devSelect <= 6'h00;
    repeat (3) @(posedge core_clk);
    chk(32'(busySenseLine), 32'h0);
    ioReset <= 1'b1;
    @(posedge core_clk);
    ioReset <= 1'b0;
    st(32'h0);
    chk(32'(transferModeLines), 32'h0);
    give_verdict();
  end
endmodule

//--- iobd_edge_detect.sv
`timescale 1ns/10ps
module iobd_edge_detect
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise
);

  logic prev_q;

  // Previous level, for leading edge recognition
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  assign rise = level & ~prev_q;

endmodule

//--- iobd_pkg.sv
package iobd_pkg;

  // Avalon register byte offsets
  localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0] REG_CONFIG_OFS = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h8;

  // Control word bit positions (write-one pulses and levels)
  localparam int CTRL_COMPLETE_BIT  = 0;
  localparam int CTRL_SYNC_SET_BIT  = 1;
  localparam int CTRL_MODE_LSB      = 2;
  localparam int CTRL_DONE_DEP_BIT  = 4;
  localparam int CTRL_BURST_EN_BIT  = 5;
  localparam int CTRL_BURST_GO_BIT  = 6;

  // Config word bit positions
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_MASK_LSB = 8;

  // Reset values
  localparam logic [5:0] DEV_CODE_RST = 6'h00;
  localparam logic [3:0] MASK_BIT_RST = 4'h0;

  // Channel transfer types as seen on the two mode lines
  typedef enum logic [1:0]
  {
    IOBD_XFER_DATA_OUT = 2'h0,
    IOBD_XFER_RSVD     = 2'h1,
    IOBD_XFER_INC_MEM  = 2'h2,
    IOBD_XFER_ADD_MEM  = 2'h3
  } iobd_xfer_t;

  // Software-written steering state
  typedef struct packed {
    iobd_xfer_t mode;
    logic       doneFromBusy;
    logic       burstEnable;
    logic [3:0] maskBit;
    logic [5:0] devCode;
  } iobd_cfg_t;

  // Observable device state
  typedef struct packed {
    logic waitLow;
    logic chanSel;
    logic chanReq;
    logic chanSync;
    logic intReq;
    logic intMask;
    logic done;
    logic busy;
  } iobd_status_t;

  // Channel request response budget
  localparam int CLK_PERIOD_NS     = 8;
  localparam int CHAN_REQ_MAX_NS   = 75;
  localparam int CHAN_REQ_MAX_CYC  = CHAN_REQ_MAX_NS / CLK_PERIOD_NS;
  localparam int CHAN_REQ_LATENCY  = 1;

endpackage
